// ### hdl/fpc_host.sv
`timescale 1ns/1ps
module fpc_host
  import fpc_pkg::*;
#(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic          req_valid_i,
  input  wire fpc_op_t       req_op_i,
  input  wire logic [AW-1:0] req_addr_i,
  input  wire logic [DW-1:0] req_data_i,
  input  wire logic          req_boot_i,
  input  wire logic          sleep_i,
  input  wire logic          vpp_ok_i,
  input  wire logic          unlock_hv_i,
  input  wire logic          boot_unlock_i,
  input  wire logic [DW-1:0] dq_i,
  output logic               req_ready_o,
  output logic               rsp_valid_o,
  output logic [DW-1:0]      rsp_data_o,
  output logic               rsp_error_o,
  output logic               ce_n_o,
  output logic               oe_n_o,
  output logic               we_n_o,
  output logic               powerdown_reset_n_o,
  output logic               hv_reset_o,
  output logic               boot_lock_n_o,
  output logic               vpp_en_o,
  output logic [AW-1:0]      addr_o,
  output logic [DW-1:0]      dq_o,
  output logic               dq_oe_n_o
);
  // Status bits are read from the low byte, and each count must fit the 8-bit counter
  if (AW < 1 || DW < 8 || FPC_WAKE_CYC > 255 || FPC_STROBE_CYC > 255 || FPC_ACCESS_CYC > 255) begin
    $error("fpc_host: unsupported width or timing count");
  end
  localparam logic [7:0] WAKE_C   = 8'(FPC_WAKE_CYC);
  localparam logic [7:0] STROBE_C = 8'(FPC_STROBE_CYC);
  localparam logic [7:0] ACCESS_C = 8'(FPC_ACCESS_CYC);

  typedef enum {
    S_PD, S_WAKE, S_IDLE, S_W1, S_GAP1, S_W2, S_GAP2,
    S_POLL, S_RA, S_RD, S_DONE
  } fpc_state_t;

  logic [DW-1:0] dq_s;
  fpc_sync2 #(.W(DW)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (dq_i),
    .q_o       (dq_s)
  );

  // Decides whether the requested target is writable at all
  function automatic logic wr_allowed(input logic vpp, input logic hv, input logic bootu, input logic boot);
    wr_allowed = vpp && (hv || bootu || !boot);
  endfunction

  fpc_state_t    st_r, st_nxt;
  logic [7:0]    cnt_r, cnt_nxt;
  fpc_op_t       op_r, op_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wdat_r, wdat_nxt;
  logic          ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, drv_r, drv_nxt;
  logic          rp_r, rp_nxt, hv_r, hv_nxt, bl_r, bl_nxt, vpp_r, vpp_nxt;
  logic          rv_r, rv_nxt, err_r, err_nxt;
  logic [DW-1:0] rdat_r, rdat_nxt;
  logic [DW-1:0] odat_r, odat_nxt;
  logic          rdy_r, rdy_nxt, oen_r, oen_nxt;

  always_comb begin
    st_nxt = st_r; cnt_nxt = cnt_r; op_nxt = op_r; addr_nxt = addr_r;
    wdat_nxt = wdat_r; ce_nxt = 1'b1; oe_nxt = 1'b1; we_nxt = 1'b1;
    drv_nxt = 1'b0; rp_nxt = rp_r; hv_nxt = hv_r; bl_nxt = bl_r; vpp_nxt = vpp_r;
    rv_nxt = 1'b0; err_nxt = err_r; rdat_nxt = rdat_r; odat_nxt = odat_r;
    case (st_r)
      S_PD: begin
        rp_nxt = 1'b0;
        vpp_nxt = 1'b0;
        if (!sleep_i) begin
          rp_nxt = 1'b1;
          cnt_nxt = WAKE_C;
          st_nxt = S_WAKE;
        end
      end
      S_WAKE: begin
        if (cnt_r > 8'h01) cnt_nxt = cnt_r - 8'h01;
        else st_nxt = S_IDLE;
      end
      S_IDLE: begin
        hv_nxt = unlock_hv_i;
        bl_nxt = boot_unlock_i;
        vpp_nxt = vpp_ok_i;
        if (sleep_i) begin
          st_nxt = S_PD;
        end else if (req_valid_i && rdy_r) begin
          op_nxt = req_op_i;
          addr_nxt = req_addr_i;
          wdat_nxt = req_data_i;
          err_nxt = 1'b0;
          if (req_op_i == FPC_OP_READ) begin
            ce_nxt = 1'b0; oe_nxt = 1'b0; addr_nxt = req_addr_i;
            cnt_nxt = ACCESS_C; st_nxt = S_RD;
          end else if ((req_op_i != FPC_OP_CLEAR) &&
                       !wr_allowed(vpp_ok_i, unlock_hv_i, boot_unlock_i, req_boot_i)) begin
            err_nxt = 1'b1; rv_nxt = 1'b1;
          end else begin
            odat_nxt = (req_op_i == FPC_OP_PROGRAM) ? DW'(FPC_CMD_PROG_SETUP) :
                       (req_op_i == FPC_OP_ERASE)   ? DW'(FPC_CMD_ERASE_SETUP) : DW'(FPC_CMD_CLEAR_STATUS);
            ce_nxt = 1'b0; we_nxt = 1'b0; drv_nxt = 1'b1; cnt_nxt = STROBE_C; st_nxt = S_W1;
          end
        end
      end
      S_W1: begin
        ce_nxt = 1'b0; we_nxt = 1'b0; drv_nxt = 1'b1;
        if (cnt_r > 8'h01) cnt_nxt = cnt_r - 8'h01;
        else begin
          ce_nxt = 1'b1; we_nxt = 1'b1; st_nxt = S_GAP1;
        end
      end
      S_GAP1: begin
        if (op_r == FPC_OP_CLEAR) begin
          odat_nxt = DW'(FPC_CMD_READ_ARRAY); st_nxt = S_RA;
        end else begin
          odat_nxt = (op_r == FPC_OP_PROGRAM) ? wdat_r : DW'(FPC_CMD_ERASE_CONF);
          st_nxt = S_W2;
        end
        ce_nxt = 1'b0; we_nxt = 1'b0; drv_nxt = 1'b1; cnt_nxt = STROBE_C;
      end
      S_W2, S_RA: begin
        ce_nxt = 1'b0; we_nxt = 1'b0; drv_nxt = 1'b1;
        if (cnt_r > 8'h01) cnt_nxt = cnt_r - 8'h01;
        else begin
          ce_nxt = 1'b1; we_nxt = 1'b1;
          st_nxt = (st_r == S_W2) ? S_GAP2 : S_DONE;
        end
      end
      S_GAP2: begin
        ce_nxt = 1'b0; oe_nxt = 1'b0; cnt_nxt = ACCESS_C; st_nxt = S_POLL;
      end
      S_POLL: begin
        ce_nxt = 1'b0; oe_nxt = 1'b0;
        if (sleep_i) begin
          // Aborted operation still answers, flagged as failed
          ce_nxt = 1'b1; oe_nxt = 1'b1; rv_nxt = 1'b1; err_nxt = 1'b1; st_nxt = S_PD;
        end
        else if (cnt_r > 8'h01) cnt_nxt = cnt_r - 8'h01;
        else if (dq_s[FPC_SR_READY_BIT]) begin
          err_nxt = dq_s[FPC_SR_VPP_BIT] | dq_s[FPC_SR_PROG_BIT] | dq_s[FPC_SR_ERASE_BIT];
          ce_nxt = 1'b1; oe_nxt = 1'b1;
          odat_nxt = DW'(FPC_CMD_READ_ARRAY); st_nxt = S_GAP1; op_nxt = FPC_OP_CLEAR;
        end else begin
          ce_nxt = 1'b1; oe_nxt = 1'b1; st_nxt = S_GAP2; // Toggle to relatch status
        end
      end
      S_RD: begin
        ce_nxt = 1'b0; oe_nxt = 1'b0;
        if (cnt_r > 8'h01) cnt_nxt = cnt_r - 8'h01;
        else begin
          rdat_nxt = dq_s; ce_nxt = 1'b1; oe_nxt = 1'b1; st_nxt = S_DONE;
        end
      end
      S_DONE: begin
        rv_nxt = 1'b1; st_nxt = S_IDLE;
      end
      default: st_nxt = S_PD;
    endcase
    rdy_nxt = (st_nxt == S_IDLE) && !rv_nxt;
    oen_nxt = !drv_nxt;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r <= S_PD; cnt_r <= 8'h00; op_r <= FPC_OP_READ; addr_r <= '0; wdat_r <= '0;
      ce_r <= 1'b1; oe_r <= 1'b1; we_r <= 1'b1; drv_r <= 1'b0; rp_r <= 1'b0;
      hv_r <= 1'b0; bl_r <= 1'b0; vpp_r <= 1'b0; rv_r <= 1'b0; err_r <= 1'b0;
      rdat_r <= '0; odat_r <= '0; rdy_r <= 1'b0; oen_r <= 1'b1;
    end else begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; op_r <= op_nxt; addr_r <= addr_nxt; wdat_r <= wdat_nxt;
      ce_r <= ce_nxt; oe_r <= oe_nxt; we_r <= we_nxt; drv_r <= drv_nxt; rp_r <= rp_nxt;
      hv_r <= hv_nxt; bl_r <= bl_nxt; vpp_r <= vpp_nxt; rv_r <= rv_nxt; err_r <= err_nxt;
      rdat_r <= rdat_nxt; odat_r <= odat_nxt; rdy_r <= rdy_nxt; oen_r <= oen_nxt;
    end
  end

  assign req_ready_o = rdy_r;
  assign rsp_valid_o = rv_r;
  assign rsp_data_o  = rdat_r;
  assign rsp_error_o = err_r;
  assign ce_n_o = ce_r;
  assign oe_n_o = oe_r;
  assign we_n_o = we_r;
  assign powerdown_reset_n_o = rp_r;
  assign hv_reset_o = hv_r;
  assign boot_lock_n_o = bl_r;
  assign vpp_en_o = vpp_r;
  assign addr_o = addr_r;
  assign dq_o = odat_r;
  assign dq_oe_n_o = oen_r;

  property p_we_needs_ce;
    @(posedge sys_clk_i) disable iff (rst_i) !we_r |-> !ce_r;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce) else $error("write strobe without chip select");
  property p_no_drive_on_read;
    @(posedge sys_clk_i) disable iff (rst_i) !oe_r |-> !drv_r;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus contention");
  property p_pd_quiet;
    @(posedge sys_clk_i) disable iff (rst_i) !rp_r |-> (we_r && ce_r);
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("access during power-down");
  sequence s_wake;
    $rose(rp_r);
  endsequence
  property p_wake_wait;
    @(posedge sys_clk_i) disable iff (rst_i) s_wake |-> ce_r [*2];
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("access before wake time");
  property p_lock_error;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rdy_r && !sleep_i && req_valid_i && req_op_i != FPC_OP_READ && req_op_i != FPC_OP_CLEAR
       && !wr_allowed(vpp_ok_i, unlock_hv_i, boot_unlock_i, req_boot_i)) |=> (rv_r && err_r && we_r);
  endproperty
  a_lock_error: assert property (p_lock_error) else $error("locked write not refused");
  property p_two_step;
    @(posedge sys_clk_i) disable iff (rst_i) (st_r == S_W2) |-> (op_r != FPC_OP_CLEAR);
  endproperty
  a_two_step: assert property (p_two_step) else $error("bad second write");
  property p_sleep_pd;
    @(posedge sys_clk_i) disable iff (rst_i) (st_r == S_IDLE && sleep_i) |=> ##1 !rp_r;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("power-down not entered");
  property p_poll_ra;
    @(posedge sys_clk_i) disable iff (rst_i) (st_r == S_POLL && st_nxt == S_GAP1) |=> odat_r == DW'(FPC_CMD_READ_ARRAY);
  endproperty
  a_poll_ra: assert property (p_poll_ra) else $error("no read-array after operation");
endmodule

// ### shared/fpc_pkg.sv
package fpc_pkg;
  localparam logic [7:0] FPC_CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] FPC_CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] FPC_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FPC_CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] FPC_CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] FPC_CMD_ERASE_CONF   = 8'hd0;
  localparam int FPC_SR_READY_BIT = 7;
  localparam int FPC_SR_ERASE_BIT = 5;
  localparam int FPC_SR_PROG_BIT  = 4;
  localparam int FPC_SR_VPP_BIT   = 3;
  localparam int FPC_CLK_MHZ      = 100;
  localparam int FPC_WAKE_NS      = 600;
  localparam int FPC_STROBE_NS    = 50;
  localparam int FPC_ACCESS_NS    = 120;
  localparam int FPC_WAKE_CYC   = (FPC_WAKE_NS * FPC_CLK_MHZ + 999) / 1000;
  localparam int FPC_STROBE_CYC = (FPC_STROBE_NS * FPC_CLK_MHZ + 999) / 1000;
  localparam int FPC_ACCESS_CYC = (FPC_ACCESS_NS * FPC_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    FPC_OP_READ,
    FPC_OP_PROGRAM,
    FPC_OP_ERASE,
    FPC_OP_CLEAR
  } fpc_op_t;
endpackage

// ### hdl/fpc_sync2.sv
`timescale 1ns/1ps
module fpc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule

// ### verification/fpc_flash_model.sv
`timescale 1ns/1ps
module fpc_flash_model #(
  parameter int BUSY_CYC = 20
) (
  input  wire logic        sys_clk_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        powerdown_reset_n_i,
  input  wire logic        hv_reset_i,
  input  wire logic        boot_lock_n_i,
  input  wire logic        vpp_en_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o
);
  logic [15:0] mem [int];
  logic [7:0]  status_r = 8'h00;
  logic        status_mode_r = 1'b0;
  logic [1:0]  pend_r = 2'd0;
  time         busy_end = 0;
  logic        flip_r = 1'b0;
  logic        locked;
  assign locked = !vpp_en_i || (addr_i[17:13] == 5'h1f && !hv_reset_i && !boot_lock_n_i);
  logic        we_q = 1'b1;
  logic        ce_q = 1'b1;
  always @(posedge sys_clk_i) begin
    we_q <= we_n_i;
    ce_q <= ce_n_i;
  end
  // Write taken one clock after the strobe rises, if chip select was low with it
  always @(posedge sys_clk_i) begin
    if (!we_q && we_n_i && !ce_q && powerdown_reset_n_i) begin
      if (pend_r != 2'd0) begin
        if (!vpp_en_i) status_r[3] = 1'b1;
        if (locked || (pend_r == 2'd2 && dq_i[7:0] != 8'hd0)) status_r[(pend_r == 2'd1) ? 4 : 5] = 1'b1;
        else if (pend_r == 2'd1) mem[addr_i] = (mem.exists(addr_i) ? mem[addr_i] : 16'hffff) & dq_i;
        else foreach (mem[k]) if (k[17:13] == addr_i[17:13]) mem[k] = 16'hffff;
        busy_end = $time + BUSY_CYC * 10;
        pend_r = 2'd0;
      end else begin
        pend_r = (dq_i[7:0] == 8'h40) ? 2'd1 : (dq_i[7:0] == 8'h20) ? 2'd2 : 2'd0;
        if (dq_i[7:0] == 8'hff) status_mode_r = 1'b0;
        if (dq_i[7:0] == 8'h70 || pend_r != 2'd0) status_mode_r = 1'b1;
        if (dq_i[7:0] == 8'h50) status_r[5:3] = 3'b000;
      end
    end
  end
  // Power-down aborts work, clears status and returns to array reads
  always @(negedge powerdown_reset_n_i) begin
    status_r = 8'h00;
    status_mode_r = 1'b0;
    pend_r = 2'd0;
    busy_end = 0;
  end
  // Released or deselected bus shows a changing pattern, never the last value
  always @(posedge sys_clk_i) begin
    flip_r <= !flip_r;
    if (!powerdown_reset_n_i || ce_n_i || oe_n_i) dq_o <= flip_r ? 16'h5a5a : 16'ha5a5;
    else if (status_mode_r) dq_o <= {8'h00, $time >= busy_end, 1'b0, status_r[5:3], 3'b000};
    else dq_o <= mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
  end
endmodule

// ### verification/flash_protect_power_control_bench.sv
`timescale 1ns/1ps
module flash_protect_power_control_bench;
  import fpc_pkg::*;
  typedef struct packed {logic chk; logic [15:0] d; logic err;} fpc_exp_t;
  logic sys_clk, rst, req_valid, req_boot, sleep, vpp_ok, unlock_hv, boot_unlock;
  fpc_op_t req_op;
  logic [17:0] req_addr, addr_o;
  logic [15:0] req_data, rsp_data_o, dq_o, flash_dq, bus_dq;
  logic req_ready_o, rsp_valid_o, rsp_error_o, ce_n_o, oe_n_o, we_n_o;
  logic powerdown_reset_n_o, hv_reset_o, boot_lock_n_o, vpp_en_o, dq_oe_n_o;
  fpc_exp_t exp_q[$];
  fpc_exp_t e;
  int num_errors = 0, compares = 0, cycles = 0, i;
  logic [15:0] d, rd [6];
  logic [3:0] tv = 4'b1110, th = 4'b0101, tu = 4'b1001, te = 4'b0011;
  assign bus_dq = dq_oe_n_o ? flash_dq : dq_o;
  fpc_host fpc_host_i (.sys_clk_i(sys_clk), .rst_i(rst), .req_valid_i(req_valid), .req_op_i(req_op),
    .req_addr_i(req_addr), .req_data_i(req_data), .req_boot_i(req_boot), .sleep_i(sleep), .vpp_ok_i(vpp_ok),
    .unlock_hv_i(unlock_hv), .boot_unlock_i(boot_unlock), .dq_i(bus_dq), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_error_o(rsp_error_o), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o), .we_n_o(we_n_o), .powerdown_reset_n_o(powerdown_reset_n_o), .hv_reset_o(hv_reset_o),
    .boot_lock_n_o(boot_lock_n_o), .vpp_en_o(vpp_en_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
  fpc_flash_model fpc_flash_model_i (.sys_clk_i(sys_clk), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .powerdown_reset_n_i(powerdown_reset_n_o), .hv_reset_i(hv_reset_o), .boot_lock_n_i(boot_lock_n_o),
    .vpp_en_i(vpp_en_o), .addr_i(addr_o), .dq_i(bus_dq), .dq_o(flash_dq));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task check(input logic [16:0] seen, input logic [16:0] expd);
    compares++;
    if (seen !== expd) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task lv(input logic v, input logic h, input logic u);
    @(posedge sys_clk);
    vpp_ok <= v;
    unlock_hv <= h;
    boot_unlock <= u;
  endtask
  task req(input fpc_op_t op, input logic [17:0] a, input logic [15:0] dd, input logic chk,
           input logic [15:0] ed, input logic err);
    int n;
    exp_q.push_back('{chk, ed, err});
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= dd;
    req_boot <= (a[17:13] == 5'h1f);
    do @(negedge sys_clk); while (req_ready_o !== 1'b1);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("MISMATCH at %0t: no response", $time);
      exp_q.delete();
    end
  endtask
  // Each response retires the oldest expectation
  always @(negedge sys_clk) begin
    if (rsp_valid_o === 1'b1) begin
      e = exp_q.pop_front();
      check({rsp_error_o, e.chk ? rsp_data_o : e.d}, {e.err, e.d});
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      test_done;
    end
  end
  initial begin
    {rst, req_valid, req_boot, sleep, unlock_hv} = 5'b10000;
    {vpp_ok, boot_unlock} = 2'b11;
    req_op = FPC_OP_READ;
    req_addr = 18'h00000;
    req_data = 16'h0000;
    void'($urandom(46));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    req(FPC_OP_READ, 18'h00100, 16'h0000, 1'b1, 16'hffff, 1'b0);
    $display("test power-up read done");
    for (i = 0; i < 4; i++) begin
      lv(tv[i], th[i], tu[i]);
      d = 16'($urandom);
      req(FPC_OP_PROGRAM, 18'h3e000 + 18'(i), d, 1'b0, 16'h0000, te[i]);
      lv(1'b1, 1'b0, 1'b1);
      req(FPC_OP_CLEAR, 18'h00000, 16'h0000, 1'b0, 16'h0000, 1'b0);
      req(FPC_OP_READ, 18'h3e000 + 18'(i), 16'h0000, 1'b1, (i < 2) ? 16'hffff : d, 1'b0);
    end
    $display("test protection table done");
    lv(1'b1, 1'b0, 1'b0);
    for (i = 0; i < 6; i++) begin
      rd[i] = 16'($urandom);
      req(FPC_OP_PROGRAM, 18'h00200 + 18'(i), rd[i], 1'b0, 16'h0000, 1'b0);
      req(FPC_OP_READ, 18'h00200 + 18'(i), 16'h0000, 1'b1, rd[i], 1'b0);
    end
    $display("test main block program done");
    lv(1'b1, 1'b1, 1'b0);
    req(FPC_OP_ERASE, 18'h3e000, 16'h0000, 1'b0, 16'h0000, 1'b0);
    req(FPC_OP_READ, 18'h3e002, 16'h0000, 1'b1, 16'hffff, 1'b0);
    lv(1'b0, 1'b1, 1'b1);
    req(FPC_OP_ERASE, 18'h00200, 16'h0000, 1'b0, 16'h0000, 1'b1);
    check({14'h0, vpp_en_o, hv_reset_o, boot_lock_n_o}, {14'h0, 3'b011});
    lv(1'b1, 1'b0, 1'b0);
    req(FPC_OP_CLEAR, 18'h00000, 16'h0000, 1'b0, 16'h0000, 1'b0);
    req(FPC_OP_READ, 18'h00200, 16'h0000, 1'b1, rd[0], 1'b0);
    $display("test erase done");
    @(posedge sys_clk);
    sleep <= 1'b1;
    i = 0;
    while (powerdown_reset_n_o !== 1'b0 && i < 200) begin
      @(negedge sys_clk);
      i++;
    end
    check({16'h0000, powerdown_reset_n_o}, 17'h00000);
    @(posedge sys_clk);
    sleep <= 1'b0;
    req(FPC_OP_READ, 18'h00201, 16'h0000, 1'b1, rd[1], 1'b0);
    $display("test power-down done");
    d = 16'($urandom);
    fork
      req(FPC_OP_PROGRAM, 18'h00300, d, 1'b0, 16'h0000, 1'b1);
      begin
        wait (oe_n_o === 1'b0);
        @(posedge sys_clk);
        sleep <= 1'b1;
      end
    join
    @(posedge sys_clk);
    sleep <= 1'b0;
    req(FPC_OP_READ, 18'h00201, 16'h0000, 1'b1, rd[1], 1'b0);
    $display("test abort done");
    test_done;
  end
endmodule
